// ---- hdl/qdw_write_path.sv ----
`timescale 1ns/10ps
`default_nettype none

module qdw_write_path #(
    parameter int DEPTH = 2
) (
    // System clock domain
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                ce,
    // Serial link
    input  wire logic                scl,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe,
    // Address straps
    input  wire logic                addr_pin_bit_zero,
    input  wire logic                addr_pin_bit_one,
    input  wire logic                ctrl_addr_bit_two,
    input  wire logic                ctrl_addr_bit_three,
    // External update strobe
    input  wire logic                async_update_pin,
    // Received bytes (link domain)
    output logic [7:0]               control_byte_reg,
    output logic [7:0]               high_byte_reg,
    output logic [7:0]               low_byte_reg,
    // Channel registers (system domain)
    output qdw_pkg::qdw_word_t       temp_reg_ch_a,
    output qdw_pkg::qdw_word_t       temp_reg_ch_b,
    output qdw_pkg::qdw_word_t       temp_reg_ch_c,
    output qdw_pkg::qdw_word_t       temp_reg_ch_d,
    output qdw_pkg::qdw_word_t       output_reg_ch_a,
    output qdw_pkg::qdw_word_t       output_reg_ch_b,
    output qdw_pkg::qdw_word_t       output_reg_ch_c,
    output qdw_pkg::qdw_word_t       output_reg_ch_d,
    // Status
    output logic                     rx_overrun
);

    //==========================================================
    // Elaboration checks
    //==========================================================
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end

    //==========================================================
    // State types
    //==========================================================
    typedef struct packed {
        qdw_pkg::qdw_link_state_t state;
        logic [3:0]               bitcnt;
        logic [7:0]               shift;
        logic                     ack_oe;
        logic                     sda_level;
        logic                     start_copy;
        logic [3:0]               strap_s1;
        logic [3:0]               strap_s2;
        logic [7:0]               ctrl;
        logic [7:0]               hb;
        logic [7:0]               lb;
        qdw_pkg::qdw_rec_t        rec;
        logic                     req_tgl;
    } qdw_link_t;

    typedef struct packed {
        logic                                  req_s1;
        logic                                  req_s2;
        logic                                  req_s3;
        logic                                  upd_s1;
        logic                                  upd_s2;
        logic                                  upd_s3;
        qdw_pkg::qdw_rec_t [DEPTH-1:0]         fifo;
        logic [PW:0]                           wptr;
        logic [PW:0]                           rptr;
        qdw_pkg::qdw_word_t [qdw_pkg::CHANNELS-1:0] temp;
        qdw_pkg::qdw_word_t [qdw_pkg::CHANNELS-1:0] dac;
        logic                                  overrun;
    } qdw_core_t;

    localparam qdw_link_t LINK_RESET = '{
        state:      qdw_pkg::LS_IDLE,
        bitcnt:     4'h0,
        shift:      qdw_pkg::BYTE_RESET,
        ack_oe:     1'b0,
        sda_level:  1'b0,
        start_copy: 1'b0,
        strap_s1:   4'h0,
        strap_s2:   4'h0,
        ctrl:       qdw_pkg::BYTE_RESET,
        hb:         qdw_pkg::BYTE_RESET,
        lb:         qdw_pkg::BYTE_RESET,
        rec:        qdw_pkg::REC_RESET,
        req_tgl:    1'b0
    };

    localparam qdw_core_t CORE_RESET = '0;

    qdw_link_t lk_reg;
    qdw_link_t lk_next;
    qdw_core_t cr_reg;
    qdw_core_t cr_next;
    logic      sda_bit_reg;
    logic      start_tgl_reg;

    //==========================================================
    // Start detection on the data line
    //==========================================================
    // Data falls while clock is high: a START or repeated START.
    // The toggle is read at the START's own clock fall, which the
    // bus hold time places safely after this edge.
    always_ff @(negedge sda_i or posedge reset) begin
        if (reset) begin
            start_tgl_reg <= 1'b0;
        end else if (scl) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    //==========================================================
    // Bit sampling at clock rise
    //==========================================================
    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            sda_bit_reg <= 1'b0;
        end else begin
            sda_bit_reg <= sda_i;
        end
    end

    //==========================================================
    // Link byte engine, clock fall
    //==========================================================
    always_comb begin
        logic       start_seen;
        logic       bc;
        logic [7:0] nbyte;
        start_seen = 1'b0;
        bc         = 1'b0;
        nbyte      = 8'h00;
        lk_next    = lk_reg;

        // Straps pass two stages before use
        lk_next.strap_s1 = {ctrl_addr_bit_three, ctrl_addr_bit_two,
                            addr_pin_bit_one, addr_pin_bit_zero};
        lk_next.strap_s2 = lk_reg.strap_s1;

        start_seen         = start_tgl_reg ^ lk_reg.start_copy;
        lk_next.start_copy = start_tgl_reg;
        nbyte              = {lk_reg.shift[6:0], sda_bit_reg};

        if (start_seen) begin
            // Restart ends any data run and re-arms addressing
            lk_next.state  = qdw_pkg::LS_ADDR;
            lk_next.bitcnt = 4'h0;
            lk_next.ack_oe = 1'b0;
        end else if (lk_reg.state != qdw_pkg::LS_IDLE) begin
            if (lk_reg.bitcnt != qdw_pkg::BIT_ACK) begin
                lk_next.shift  = nbyte;
                lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
                // Pull data low for the ninth clock when accepted
                if (lk_reg.bitcnt == qdw_pkg::BIT_LAST) begin
                    unique case (lk_reg.state)
                        qdw_pkg::LS_ADDR: begin
                            lk_next.ack_oe = (nbyte[7:1] == {qdw_pkg::ADDR_FIXED,
                                             lk_reg.strap_s2[1:0]}) && !nbyte[0];
                        end
                        qdw_pkg::LS_IDLE,
                        qdw_pkg::LS_IGNORE: begin
                            lk_next.ack_oe = 1'b0;
                        end
                        qdw_pkg::LS_CTRL,
                        qdw_pkg::LS_DATA_HI,
                        qdw_pkg::LS_DATA_LO,
                        qdw_pkg::LS_PD_HI,
                        qdw_pkg::LS_PD_LO: begin
                            lk_next.ack_oe = 1'b1;
                        end
                    endcase
                end
            end else begin
                // Falling edge that ends the acknowledge clock
                lk_next.ack_oe = 1'b0;
                lk_next.bitcnt = 4'h0;
                unique case (lk_reg.state)
                    qdw_pkg::LS_ADDR: begin
                        // Acked only on a matching write address
                        lk_next.state = lk_reg.ack_oe ? qdw_pkg::LS_CTRL
                                                      : qdw_pkg::LS_IGNORE;
                    end
                    qdw_pkg::LS_CTRL: begin
                        lk_next.ctrl = lk_reg.shift;
                        bc = (lk_reg.shift[qdw_pkg::CTRL_LOAD_LSB+:2] == qdw_pkg::LOAD_BCAST);
                        if (!bc && lk_reg.shift[qdw_pkg::CTRL_ADDR_LSB+:2] != lk_reg.strap_s2[3:2]) begin
                            lk_next.state = qdw_pkg::LS_IGNORE;
                        end else if (bc && !lk_reg.shift[qdw_pkg::CTRL_BC_DATA]) begin
                            // Broadcast update from stored temps, no data follows
                            lk_next.rec          = qdw_pkg::REC_RESET;
                            lk_next.rec.load     = qdw_pkg::LOAD_BCAST;
                            lk_next.req_tgl      = ~lk_reg.req_tgl;
                            lk_next.state        = qdw_pkg::LS_IGNORE;
                        end else if (lk_reg.shift[qdw_pkg::CTRL_PD_BIT]) begin
                            lk_next.state = qdw_pkg::LS_PD_HI;
                        end else begin
                            lk_next.state = qdw_pkg::LS_DATA_HI;
                        end
                    end
                    qdw_pkg::LS_DATA_HI: begin
                        lk_next.hb    = lk_reg.shift;
                        lk_next.state = qdw_pkg::LS_DATA_LO;
                    end
                    qdw_pkg::LS_DATA_LO: begin
                        lk_next.lb            = lk_reg.shift;
                        lk_next.rec.chan      = lk_reg.ctrl[qdw_pkg::CTRL_CH_LSB+:2];
                        lk_next.rec.load      = lk_reg.ctrl[qdw_pkg::CTRL_LOAD_LSB+:2];
                        lk_next.rec.pd        = 1'b0;
                        lk_next.rec.has_data  = 1'b1;
                        lk_next.rec.pdcode    = qdw_pkg::PD_NORMAL;
                        lk_next.rec.data      = {lk_reg.hb, lk_reg.shift};
                        lk_next.req_tgl       = ~lk_reg.req_tgl;
                        lk_next.state         = qdw_pkg::LS_DATA_HI;
                    end
                    qdw_pkg::LS_PD_HI: begin
                        lk_next.hb    = lk_reg.shift;
                        lk_next.state = qdw_pkg::LS_PD_LO;
                    end
                    qdw_pkg::LS_PD_LO: begin
                        lk_next.lb            = lk_reg.shift;
                        lk_next.rec.chan      = lk_reg.ctrl[qdw_pkg::CTRL_CH_LSB+:2];
                        lk_next.rec.load      = lk_reg.ctrl[qdw_pkg::CTRL_LOAD_LSB+:2];
                        lk_next.rec.pd        = 1'b1;
                        lk_next.rec.has_data  = 1'b1;
                        lk_next.rec.pdcode    = lk_reg.hb[qdw_pkg::HB_PD_LSB+:2];
                        lk_next.rec.data      = {lk_reg.hb, lk_reg.shift};
                        lk_next.req_tgl       = ~lk_reg.req_tgl;
                        lk_next.state         = qdw_pkg::LS_IGNORE;
                    end
                    qdw_pkg::LS_IDLE,
                    qdw_pkg::LS_IGNORE: begin
                        lk_next.state = lk_reg.state;
                    end
                endcase
            end
        end
    end

    // Async reset: the link clock may be still while reset is held
    always_ff @(negedge scl or posedge reset) begin
        if (reset) begin
            lk_reg <= LINK_RESET;
        end else begin
            lk_reg <= lk_next;
        end
    end

    //==========================================================
    // Core: crossing, DEPTH-entry buffer, channel registers
    //==========================================================
    always_comb begin
        logic              req_evt;
        logic              upd_evt;
        logic              full;
        logic              empty;
        logic              bc;
        logic              sel;
        logic              load_it;
        qdw_pkg::qdw_rec_t e;
        qdw_pkg::qdw_word_t newt;
        req_evt = 1'b0;
        upd_evt = 1'b0;
        full    = 1'b0;
        empty   = 1'b0;
        bc      = 1'b0;
        sel     = 1'b0;
        load_it = 1'b0;
        e       = qdw_pkg::REC_RESET;
        newt    = qdw_pkg::WORD_RESET;
        cr_next = cr_reg;

        // Toggle and pin pass two stages, third stage for edges
        cr_next.req_s1 = lk_reg.req_tgl;
        cr_next.req_s2 = cr_reg.req_s1;
        cr_next.req_s3 = cr_reg.req_s2;
        cr_next.upd_s1 = async_update_pin;
        cr_next.upd_s2 = cr_reg.upd_s1;
        cr_next.upd_s3 = cr_reg.upd_s2;
        req_evt = cr_reg.req_s2 ^ cr_reg.req_s3;
        upd_evt = cr_reg.upd_s2 & ~cr_reg.upd_s3;
        full    = (cr_reg.wptr - cr_reg.rptr) == (PW + 1)'(DEPTH);
        empty   = (cr_reg.wptr == cr_reg.rptr);

        // Fill side: record is stable long after its toggle
        if (req_evt) begin
            if (!full) begin
                cr_next.fifo[cr_reg.wptr[PW-1:0]] = lk_reg.rec;
                cr_next.wptr = cr_reg.wptr + (PW + 1)'(1);
            end else begin
                cr_next.overrun = 1'b1;
            end
        end

        // Pin load wins the cycle; the buffer holds the word meanwhile
        if (upd_evt) begin
            for (int i = 0; i < qdw_pkg::CHANNELS; i++) begin
                cr_next.dac[i] = cr_reg.temp[i];
            end
        end else if (!empty) begin
            e  = cr_reg.fifo[cr_reg.rptr[PW-1:0]];
            bc = (e.load == qdw_pkg::LOAD_BCAST);
            cr_next.rptr = cr_reg.rptr + (PW + 1)'(1);
            for (int i = 0; i < qdw_pkg::CHANNELS; i++) begin
                sel  = bc || (e.chan == 2'(i));
                // Power-down keeps the stored data word
                newt = e.pd ? {e.pdcode, cr_reg.temp[i][qdw_pkg::DATA_W-1:0]}
                            : {qdw_pkg::PD_NORMAL, e.data};
                load_it = !e.has_data || bc || (e.load == qdw_pkg::LOAD_ALL) ||
                          ((e.load == qdw_pkg::LOAD_ONE) && (e.chan == 2'(i)));
                if (e.has_data && sel) begin
                    cr_next.temp[i] = newt;
                end
                if (load_it) begin
                    cr_next.dac[i] = (e.has_data && sel) ? newt : cr_reg.temp[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cr_reg <= CORE_RESET;
        end else if (ce) begin
            cr_reg <= cr_next;
        end
    end

    //==========================================================
    // Outputs, all from flops
    //==========================================================
    assign sda_o            = lk_reg.sda_level;
    assign sda_oe           = lk_reg.ack_oe;
    assign control_byte_reg = lk_reg.ctrl;
    assign high_byte_reg    = lk_reg.hb;
    assign low_byte_reg     = lk_reg.lb;
    assign temp_reg_ch_a    = cr_reg.temp[0];
    assign temp_reg_ch_b    = cr_reg.temp[1];
    assign temp_reg_ch_c    = cr_reg.temp[2];
    assign temp_reg_ch_d    = cr_reg.temp[3];
    assign output_reg_ch_a  = cr_reg.dac[0];
    assign output_reg_ch_b  = cr_reg.dac[1];
    assign output_reg_ch_c  = cr_reg.dac[2];
    assign output_reg_ch_d  = cr_reg.dac[3];
    assign rx_overrun       = cr_reg.overrun;

endmodule : qdw_write_path

`default_nettype wire

// ---- hdl/qdw_pkg.sv ----
//==============================================================
// Shared constants and carriers
//==============================================================
package qdw_pkg;

    //==========================================================
    // Widths
    //==========================================================
    localparam int CHANNELS = 4;
    localparam int BYTE_W   = 8;
    localparam int DATA_W   = 16;
    localparam int PD_W     = 2;
    localparam int WORD_W   = DATA_W + PD_W;

    //==========================================================
    // Address and control byte layout
    //==========================================================
    localparam logic [4:0] ADDR_FIXED     = 5'h13;  // 10011
    localparam int         CTRL_PD_BIT    = 0;
    localparam int         CTRL_CH_LSB    = 1;
    localparam int         CTRL_BC_DATA   = 2;
    localparam int         CTRL_LOAD_LSB  = 4;
    localparam int         CTRL_ADDR_LSB  = 6;
    localparam int         HB_PD_LSB      = 6;
    localparam logic [1:0] LOAD_TEMP      = 2'h0;
    localparam logic [1:0] LOAD_ONE       = 2'h1;
    localparam logic [1:0] LOAD_ALL       = 2'h2;
    localparam logic [1:0] LOAD_BCAST     = 2'h3;
    localparam logic [1:0] PD_NORMAL      = 2'h0;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_ACK        = 4'h8;

    //==========================================================
    // Reset values
    //==========================================================
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [17:0] WORD_RESET = 18'h00000;

    //==========================================================
    // Types
    //==========================================================
    typedef logic [WORD_W-1:0] qdw_word_t;

    typedef enum logic [2:0] {
        LS_IDLE    = 3'h0,
        LS_ADDR    = 3'h1,
        LS_CTRL    = 3'h3,
        LS_DATA_HI = 3'h2,
        LS_DATA_LO = 3'h6,
        LS_PD_HI   = 3'h7,
        LS_PD_LO   = 3'h5,
        LS_IGNORE  = 3'h4
    } qdw_link_state_t;

    // One finished write, handed from the link to the core
    typedef struct packed {
        logic [1:0]        chan;
        logic [1:0]        load;
        logic              pd;
        logic              has_data;
        logic [PD_W-1:0]   pdcode;
        logic [DATA_W-1:0] data;
    } qdw_rec_t;

    localparam qdw_rec_t REC_RESET = '0;

endpackage : qdw_pkg

// ---- test/qdw_write_path_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
//====================================
// Port checker for the write path
module qdw_write_path_assertions (
    // Clocks and control
    input wire logic               mclk,
    input wire logic               reset,
    input wire logic               ce,
    input wire logic               scl,
    input wire logic               async_update_pin,
    // Link outputs
    input wire logic               sda_o,
    input wire logic               sda_oe,
    input wire logic [7:0]         control_byte_reg,
    input wire logic [7:0]         high_byte_reg,
    input wire logic [7:0]         low_byte_reg,
    // Channel registers
    input wire qdw_pkg::qdw_word_t temp_reg_ch_a,
    input wire qdw_pkg::qdw_word_t temp_reg_ch_b,
    input wire qdw_pkg::qdw_word_t temp_reg_ch_c,
    input wire qdw_pkg::qdw_word_t temp_reg_ch_d,
    input wire qdw_pkg::qdw_word_t output_reg_ch_a,
    input wire qdw_pkg::qdw_word_t output_reg_ch_b,
    input wire qdw_pkg::qdw_word_t output_reg_ch_c,
    input wire qdw_pkg::qdw_word_t output_reg_ch_d
);
    // Sampled history is only valid from the second link fall after reset
    logic scl_seen_reg;
    always_ff @(negedge scl or posedge reset) begin
        if (reset) begin
            scl_seen_reg <= 1'b0;
        end else begin
            scl_seen_reg <= 1'b1;
        end
    end
    // Open-drain pin: only ever pulls low
    a_ack_pull_low: assert property (@(posedge scl) disable iff (reset) sda_oe |-> !sda_o)
        else $error("ack drives line high");
    a_ack_one_period: assert property (@(negedge scl) disable iff (reset) sda_oe |=> !sda_oe)
        else $error("ack held too long");
    // Byte registers move only as their ack ends
    a_ctrl_after_ack: assert property (@(negedge scl) disable iff (reset)
        scl_seen_reg && !$stable(control_byte_reg) |-> $past(sda_oe))
        else $error("control byte changed off ack");
    a_high_after_ack: assert property (@(negedge scl) disable iff (reset)
        scl_seen_reg && !$stable(high_byte_reg) |-> $past(sda_oe))
        else $error("high byte changed off ack");
    a_low_after_ack: assert property (@(negedge scl) disable iff (reset)
        scl_seen_reg && !$stable(low_byte_reg) |-> $past(sda_oe))
        else $error("low byte changed off ack");
    // Strobe copies every temp within a few cycles
    a_update_copies: assert property (@(posedge mclk) disable iff (reset) $rose(async_update_pin) && ce |-> ##[2:5]
        ({temp_reg_ch_a, temp_reg_ch_b, temp_reg_ch_c, temp_reg_ch_d} ==
         {output_reg_ch_a, output_reg_ch_b, output_reg_ch_c, output_reg_ch_d}))
        else $error("update strobe did not copy");
    a_reset_zero: assert property (@(posedge mclk) $fell(reset) |-> (temp_reg_ch_a | temp_reg_ch_b | temp_reg_ch_c |
        temp_reg_ch_d | output_reg_ch_a | output_reg_ch_b | output_reg_ch_c | output_reg_ch_d) == '0)
        else $error("registers not cleared");
    a_freeze_no_ce: assert property (@(posedge mclk) disable iff (reset) !ce |=> $stable(temp_reg_ch_a) && $stable(output_reg_ch_a))
        else $error("core moved while frozen");
endmodule : qdw_write_path_assertions
bind qdw_write_path qdw_write_path_assertions qdw_write_path_assertions_inst (.mclk, .reset, .ce, .scl,
    .async_update_pin, .sda_o, .sda_oe, .control_byte_reg, .high_byte_reg, .low_byte_reg, .temp_reg_ch_a,
    .temp_reg_ch_b, .temp_reg_ch_c, .temp_reg_ch_d, .output_reg_ch_a, .output_reg_ch_b, .output_reg_ch_c,
    .output_reg_ch_d);
`default_nettype wire

// ---- test/qdw_i2c_master.sv ----
`timescale 1ns/10ps
`default_nettype none
//====================================
// Bus master; clock stands high between frames
module qdw_i2c_master (
    // Bus lines, open drain
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // Idle bus released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start or repeated start, data falls while clock high
    task automatic start;
        scl = 1'b0;
        #10 sda_low = 1'b0;
        #30 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
    endtask : start
    // One byte, msb first, then ack sampled on the ninth rise
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #10 sda_low = ~b[i];
            #30 scl = 1'b1;
            #40 scl = 1'b0;
        end
        #10 sda_low = 1'b0;
        #30 scl = 1'b1;
        ack = ~sda;
        #40 scl = 1'b0;
    endtask : send
    // Stop, leaving both lines high
    task automatic stop;
        #10 sda_low = 1'b1;
        #30 scl = 1'b1;
        #20 sda_low = 1'b0;
    endtask : stop
endmodule : qdw_i2c_master
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
//====================================
// Write path bench
module testbench;
    localparam logic [7:0] ADR = {qdw_pkg::ADDR_FIXED, 2'b10, 1'b0};
    logic               mclk = 1'b0;
    logic               reset = 1'b0;
    logic               ce = 1'b1;
    logic               upd = 1'b0;
    logic               scl;
    logic               m_low;
    logic               sda_o;
    logic               sda_oe;
    logic               ovr;
    logic [7:0]         cb;
    logic [7:0]         hb;
    logic [7:0]         lb;
    qdw_pkg::qdw_word_t tmp [4];
    qdw_pkg::qdw_word_t dac [4];
    qdw_pkg::qdw_word_t exp_t [4] = '{default: '0};
    qdw_pkg::qdw_word_t exp_d [4] = '{default: '0};
    int                 miscompares = 0;
    int                 num_checks = 0;
    wire logic          sda;
    // Pull-up wire: low if anyone pulls
    assign sda = !(m_low || (sda_oe && !sda_o));
    always #50 mclk = ~mclk;
    qdw_i2c_master qdw_i2c_master_inst (.scl, .sda_low(m_low), .sda);
    qdw_write_path qdw_write_path_inst (.mclk, .reset, .ce, .scl, .sda_i(sda), .sda_o, .sda_oe,
        .addr_pin_bit_zero(1'b0), .addr_pin_bit_one(1'b1), .ctrl_addr_bit_two(1'b1),
        .ctrl_addr_bit_three(1'b0), .async_update_pin(upd), .control_byte_reg(cb), .high_byte_reg(hb),
        .low_byte_reg(lb), .temp_reg_ch_a(tmp[0]), .temp_reg_ch_b(tmp[1]), .temp_reg_ch_c(tmp[2]),
        .temp_reg_ch_d(tmp[3]), .output_reg_ch_a(dac[0]), .output_reg_ch_b(dac[1]),
        .output_reg_ch_c(dac[2]), .output_reg_ch_d(dac[3]), .rx_overrun(ovr));
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_all;
        for (int i = 0; i < 4; i++) begin
            chk("temp", exp_t[i], tmp[i]);
            chk("dac", exp_d[i], dac[i]);
        end
    endtask : chk_all
    // First nack bytes must be acked, later ones refused
    task automatic frame(input logic [7:0] b [6], input int n, input int nack);
        logic a;
        qdw_i2c_master_inst.start();
        for (int i = 0; i < n; i++) begin
            qdw_i2c_master_inst.send(b[i], a);
            chk("ack", 18'(i < nack), 18'(a));
        end
        qdw_i2c_master_inst.stop();
        repeat (8) @(posedge mclk);
    endtask : frame
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // Watchdog so no frame hangs the run
    initial begin
        #2000000 miscompares++;
        conclude();
    end
    initial begin
        // A real rising edge, so the link flops see their async reset
        #1 reset = 1'b1;
        repeat (4) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (3) @(posedge mclk);
        chk_all();
        chk("ctrl", 0, cb);
        for (int c = 0; c < 4; c++) begin
            frame('{ADR, 8'h40 | 8'(c << 1), 8'h10 + 8'(c), 8'h34, 0, 0}, 4, 4);
            exp_t[c] = {2'b00, 8'h10 + 8'(c), 8'h34};
            chk_all();
            chk("ctrl", 8'h40 | 8'(c << 1), cb);
        end
        frame('{ADR, 8'h52, 8'hA5, 8'hC3, 0, 0}, 4, 4);
        exp_t[1] = 18'h0A5C3;
        exp_d[1] = exp_t[1];
        chk_all();
        chk("high", 8'hA5, hb);
        chk("low", 8'hC3, lb);
        frame('{ADR, 8'h64, 8'h0F, 8'h0F, 0, 0}, 4, 4);
        exp_t[2] = 18'h00F0F;
        exp_d = exp_t;
        chk_all();
        $display("test load codes done");
        frame('{ADR, 8'h46, 8'h11, 8'h22, 8'h33, 8'h44}, 6, 6);
        exp_t[3] = 18'h03344;
        chk_all();
        // Strobe only after the temps are written
        @(posedge mclk) #1 upd = 1'b1;
        repeat (3) @(posedge mclk);
        #1 upd = 1'b0;
        repeat (8) @(posedge mclk);
        exp_d = exp_t;
        chk_all();
        frame('{ADR, 8'h51, 8'hC0, 8'h00, 8'hAA, 0}, 5, 4);
        exp_t[0][17:16] = 2'b11;
        exp_d[0] = exp_t[0];
        chk_all();
        frame('{ADR ^ 8'h02, 8'h40, 8'h99, 8'h99, 0, 0}, 4, 0);
        frame('{ADR | 8'h01, 8'h40, 0, 0, 0, 0}, 2, 0);
        frame('{ADR, 8'hC0, 8'h99, 8'h99, 0, 0}, 4, 2);
        chk_all();
        frame('{ADR, 8'h34, 8'h55, 8'h55, 0, 0}, 4, 4);
        exp_t = '{default: 18'h05555};
        exp_d = exp_t;
        chk_all();
        $display("test strobe power-down foreign done");
        // Frozen core holds the crossing too, so only one word may arrive meanwhile
        @(posedge mclk) #1 ce = 1'b0;
        frame('{ADR, 8'h40, 8'h70, 8'h00, 0, 0}, 4, 4);
        chk("overrun", 0, ovr);
        chk_all();
        @(posedge mclk) #1 ce = 1'b1;
        repeat (8) @(posedge mclk);
        exp_t[0] = 18'h07000;
        for (int c = 1; c < 3; c++) begin
            frame('{ADR, 8'h40 | 8'(c << 1), 8'h70, 8'(c), 0, 0}, 4, 4);
            exp_t[c] = {2'b00, 8'h70, 8'(c)};
        end
        chk_all();
        // Broadcast update without data: DACs take the stored temps, a third byte is refused
        frame('{ADR, 8'h30, 8'hFF, 0, 0, 0}, 3, 2);
        exp_d = exp_t;
        chk_all();
        $display("test buffer done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
